// ===== include/calc_pkg.sv
// constants and types shared by the stamp result calculator and its divider
// assumes a single 100 MHz clock domain and an AXI4-Lite register master
package calc_pkg;

  // ==========================================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DW = 64;

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] EV_CORR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] TM_CORR_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] PATH_OFS_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] REF_PER_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] REF_FREQ_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] SUM_LO_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] SUM_HI_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h24;

  // ==========================================================================
  // control fields, reset value
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_PRESCALE_BIT = 3;
  localparam int CTRL_ARMFMT_BIT = 4;
  localparam int CTRL_AUTO_BIT = 5;
  localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;

  // ==========================================================================
  // record layout: low bits interpolator, then two status flags
  localparam int STAT_W = 8;
  localparam int INTERP_W = 6;
  localparam int STAT_START_BIT = 6;
  localparam int STAT_INHIBIT_BIT = 7;

  // ==========================================================================
  // arithmetic units; time stamps are kept in 0.1 ns steps
  localparam int TICK_PS = 2000;
  localparam int INTERP_PS = 100;
  localparam logic [DW-1:0] TICK_STEPS = DW'(TICK_PS / INTERP_PS);
  localparam int PRESCALE_SHIFT = 2;
  localparam int FREQ_FRAC = 32;
  localparam int PER_FRAC = 8;
  localparam int PHASE_FRAC = 8;
  localparam logic [DW-1:0] DEG_FULL = 64'h0000_0000_0000_0168;

  // ==========================================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FN_CTI = 3'h0,
    FN_FREQ = 3'h1,
    FN_PERIOD = 3'h2,
    FN_TDEV = 3'h3,
    FN_PDEV = 3'h4,
    FN_FDEV = 3'h5
  } func_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_STAMP = 2'h1,
    ST_DIVIDE = 2'h3
  } state_t;

endpackage

// ===== include/div_if.sv
// handshake between the calculator and its sequential divider
// assumes both ends share one clock
`timescale 1ns/100ps
`default_nettype none
interface div_if #(parameter int W = 64);
  logic start;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic [W-1:0] quotient;
  logic busy;
  logic done;
  logic zero;
  modport client(output start, output dividend, output divisor,
                 input quotient, input busy, input done, input zero);
  modport worker(input start, input dividend, input divisor,
                 output quotient, output busy, output done, output zero);
endinterface
`default_nettype wire

// ===== logic/stamp_divider.sv
// signed restoring divider, one quotient bit per clock
// assumes start is raised only while busy is low
`timescale 1ns/100ps
`default_nettype none
module stamp_divider #(
  parameter int W = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  div_if.worker dv
);
  import calc_pkg::*;
  localparam int CW = $clog2(W);

  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic zero_reg, zero_next;
  logic neg_reg, neg_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [W-1:0] rem_reg, rem_next;
  logic [W-1:0] quo_reg, quo_next;
  logic [W-1:0] den_reg, den_next;
  logic [W-1:0] q_reg, q_next;
  logic [W:0] trial;

  // ==========================================================================
  // iteration
  // magnitudes are divided; sign fixed once at the end
  always_comb begin
    busy_next = busy_reg;
    zero_next = zero_reg;
    neg_next = neg_reg;
    cnt_next = cnt_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    den_next = den_reg;
    q_next = q_reg;
    done_next = 1'b0;
    trial = {rem_reg, quo_reg[W-1]};
    if (busy_reg) begin
      if (trial >= {1'b0, den_reg}) begin
        rem_next = W'(trial - {1'b0, den_reg});
        quo_next = {quo_reg[W-2:0], 1'b1};
      end else begin
        rem_next = trial[W-1:0];
        quo_next = {quo_reg[W-2:0], 1'b0};
      end
      cnt_next = cnt_reg - 1'b1;
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        q_next = neg_reg ? W'(-quo_next) : quo_next;
      end
    end else if (dv.start) begin
      zero_next = (dv.divisor == '0); // no value, flagged instead
      busy_next = (dv.divisor != '0);
      done_next = (dv.divisor == '0);
      neg_next = dv.dividend[W-1] ^ dv.divisor[W-1];
      quo_next = dv.dividend[W-1] ? W'(-dv.dividend) : dv.dividend;
      den_next = dv.divisor[W-1] ? W'(-dv.divisor) : dv.divisor;
      rem_next = '0;
      cnt_next = CW'(W - 1);
      q_next = '0;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      zero_reg <= 1'b0;
      neg_reg <= 1'b0;
      cnt_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      den_reg <= '0;
      q_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      zero_reg <= zero_next;
      neg_reg <= neg_next;
      cnt_reg <= cnt_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      den_reg <= den_next;
      q_reg <= q_next;
    end
  end

  assign dv.quotient = q_reg;
  assign dv.busy = busy_reg;
  assign dv.done = done_reg;
  assign dv.zero = zero_reg;
endmodule
`default_nettype wire

// ===== logic/stamp_result_calculator.sv
// turns raw capture records into interval, frequency and deviation results
// assumes records come from logic on CLK and registers from an AXI4-Lite
// master; the result consumer never stalls
//
// What this block does
// - prescaled channel counts one per four events
// - arming format first record holds arming time
// - arming record event field is unused
// - only block-start and inhibit flags matter
// - block-start flag is status bit six
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module stamp_result_calculator #(
  parameter int EV_W = 32,
  parameter int TM_W = 32
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [calc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [calc_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [calc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [calc_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic REC_VALID,
  output logic REC_READY,
  input wire logic [EV_W-1:0] REC_EVENT,
  input wire logic [TM_W-1:0] REC_TIME,
  input wire logic [calc_pkg::STAT_W-1:0] REC_STAT,
  output logic RES_VALID,
  output logic [calc_pkg::DW-1:0] RES_VALUE,
  output logic [calc_pkg::DW-1:0] RES_AUX,
  output logic RES_INVALID,
  output logic [2:0] RES_FUNC
);
  import calc_pkg::*;

  typedef struct packed {
    logic aw_ok;
    logic [ADDR_W-1:0] awaddr;
    logic w_ok;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] ev_corr;
    logic [DATA_W-1:0] tm_corr;
    logic [DATA_W-1:0] path_ofs;
    logic [DATA_W-1:0] ref_per;
    logic [DATA_W-1:0] ref_freq;
  } axi_t;

  typedef struct packed {
    state_t st;
    logic [EV_W-1:0] ev_raw;
    logic [EV_W-1:0] ev_prev;
    logic [TM_W-1:0] tm_raw;
    logic [TM_W-1:0] tm_prev;
    logic [STAT_W-1:0] stat;
    logic [DW-1:0] ev_acc;
    logic [DW-1:0] tm_acc;
    logic [DW-1:0] prev_es;
    logic [DW-1:0] prev_ts;
    logic [DW-1:0] ref_es;
    logic [DW-1:0] ref_ts;
    logic [DW-1:0] dt;
    logic ev_have;
    logic have_prev;
    logic prev_arm;
    logic have_ref;
    func_t func;
    logic [DW-1:0] sum;
    logic [DATA_W-1:0] cnt;
    logic res_valid;
    logic res_invalid;
    func_t res_func;
    logic [DW-1:0] res_value;
    logic [DW-1:0] res_aux;
  } calc_t;

  axi_t a_reg, a_next;
  calc_t c_reg, c_next;
  div_if #(.W(DW)) dv ();

  // ==========================================================================
  // register decode, shared by read and write
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] ad);
    if (ad == CTRL_OFS) reg_sel = 4'h1;
    else if (ad == EV_CORR_OFS) reg_sel = 4'h2;
    else if (ad == TM_CORR_OFS) reg_sel = 4'h3;
    else if (ad == PATH_OFS_OFS) reg_sel = 4'h4;
    else if (ad == REF_PER_OFS) reg_sel = 4'h5;
    else if (ad == REF_FREQ_OFS) reg_sel = 4'h6;
    else if (ad == STATUS_OFS) reg_sel = 4'h7;
    else if (ad == SUM_LO_OFS) reg_sel = 4'h8;
    else if (ad == SUM_HI_OFS) reg_sel = 4'h9;
    else if (ad == COUNT_OFS) reg_sel = 4'hA;
    else reg_sel = 4'h0;
  endfunction

  function automatic logic [DATA_W-1:0] strb_merge(
      input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] dat,
      input logic [3:0] strb);
    strb_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) strb_merge[i*8 +: 8] = dat[i*8 +: 8];
    end
  endfunction

  // ==========================================================================
  // AXI4-Lite slave
  // address and data are parked separately so either may come first
  always_comb begin
    logic [3:0] sel;
    sel = 4'h0;
    a_next = a_reg;
    if (S_AXI_AWVALID && !a_reg.aw_ok) begin
      a_next.aw_ok = 1'b1;
      a_next.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !a_reg.w_ok) begin
      a_next.w_ok = 1'b1;
      a_next.wdata = S_AXI_WDATA;
      a_next.wstrb = S_AXI_WSTRB;
    end
    if (a_reg.bvalid && S_AXI_BREADY) a_next.bvalid = 1'b0;
    if (a_reg.aw_ok && a_reg.w_ok && !a_reg.bvalid) begin
      sel = reg_sel(a_reg.awaddr);
      a_next.aw_ok = 1'b0;
      a_next.w_ok = 1'b0;
      a_next.bvalid = 1'b1;
      a_next.bresp = (sel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
      case (sel)
        4'h1: a_next.ctrl = strb_merge(a_reg.ctrl, a_reg.wdata, a_reg.wstrb);
        4'h2: a_next.ev_corr =
            strb_merge(a_reg.ev_corr, a_reg.wdata, a_reg.wstrb);
        4'h3: a_next.tm_corr =
            strb_merge(a_reg.tm_corr, a_reg.wdata, a_reg.wstrb);
        4'h4: a_next.path_ofs =
            strb_merge(a_reg.path_ofs, a_reg.wdata, a_reg.wstrb);
        4'h5: a_next.ref_per =
            strb_merge(a_reg.ref_per, a_reg.wdata, a_reg.wstrb);
        4'h6: a_next.ref_freq =
            strb_merge(a_reg.ref_freq, a_reg.wdata, a_reg.wstrb);
        default: ; // status and mean registers are read-only
      endcase
    end
    if (a_reg.rvalid && S_AXI_RREADY) a_next.rvalid = 1'b0;
    if (S_AXI_ARVALID && !a_reg.rvalid) begin
      a_next.rvalid = 1'b1;
      a_next.rresp = RESP_OKAY;
      case (reg_sel(S_AXI_ARADDR))
        4'h1: a_next.rdata = a_reg.ctrl;
        4'h2: a_next.rdata = a_reg.ev_corr;
        4'h3: a_next.rdata = a_reg.tm_corr;
        4'h4: a_next.rdata = a_reg.path_ofs;
        4'h5: a_next.rdata = a_reg.ref_per;
        4'h6: a_next.rdata = a_reg.ref_freq;
        4'h7: a_next.rdata = {28'h0000000, c_reg.st, c_reg.have_ref,
                              c_reg.have_prev};
        4'h8: a_next.rdata = c_reg.sum[31:0];
        4'h9: a_next.rdata = c_reg.sum[63:32];
        4'hA: a_next.rdata = c_reg.cnt;
        default: begin
          a_next.rdata = REG_RST;
          a_next.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) a_reg <= '0;
    else a_reg <= a_next;
  end

  assign S_AXI_AWREADY = !a_reg.aw_ok;
  assign S_AXI_WREADY = !a_reg.w_ok;
  assign S_AXI_BVALID = a_reg.bvalid;
  assign S_AXI_BRESP = a_reg.bresp;
  assign S_AXI_ARREADY = !a_reg.rvalid;
  assign S_AXI_RVALID = a_reg.rvalid;
  assign S_AXI_RDATA = a_reg.rdata;
  assign S_AXI_RRESP = a_reg.rresp;

  // ==========================================================================
  // stamp and result datapath
  always_comb begin
    logic start, arm_first, armfmt, ev_wrap, tm_wrap, pair_ok, hv_ref;
    logic [DW-1:0] ev_acc, tm_acc, es, ts, de, dt, r_es, r_ts, tdev;
    func_t fn;
    fn = func_t'(a_reg.ctrl[CTRL_FUNC_LSB +: 3]);
    armfmt = a_reg.ctrl[CTRL_ARMFMT_BIT];
    start = c_reg.stat[STAT_START_BIT]; // block-start flag
    arm_first = armfmt && start; // arming record
    // a new block forgets earlier rollover counts and the reference
    ev_acc = start ? '0 : c_reg.ev_acc;
    tm_acc = start ? '0 : c_reg.tm_acc;
    hv_ref = start ? 1'b0 : c_reg.have_ref;
    pair_ok = !start && c_reg.have_prev && !c_reg.prev_arm;
    // unused event field never enters the
    ev_wrap = !start && c_reg.ev_have && !arm_first &&
              (c_reg.ev_raw < c_reg.ev_prev);
    tm_wrap = !start && (c_reg.tm_raw < c_reg.tm_prev);
    if (ev_wrap) ev_acc = ev_acc + DW'(a_reg.ev_corr);
    if (tm_wrap) tm_acc = tm_acc + DW'(a_reg.tm_corr);
    es = DW'(c_reg.ev_raw) + ev_acc;
    // counter saw one of four events; scale after the wrap fix
    if (a_reg.ctrl[CTRL_PRESCALE_BIT]) es = es << PRESCALE_SHIFT;
    ts = (DW'(c_reg.tm_raw) + tm_acc) * TICK_STEPS -
         DW'(c_reg.stat[INTERP_W-1:0]);
    if (arm_first) ts = ts - DW'(a_reg.path_ofs);
    de = es - c_reg.prev_es;
    dt = ts - c_reg.prev_ts;
    r_es = hv_ref ? c_reg.ref_es : es;
    r_ts = hv_ref ? c_reg.ref_ts : ts;
    // sign falls out naturally: late edges give negative values
    tdev = (es - r_es) * DW'(a_reg.ref_per) - (ts - r_ts);
    c_next = c_reg;
    c_next.res_valid = 1'b0;
    dv.start = 1'b0;
    dv.dividend = '0;
    dv.divisor = '0;
    case (c_reg.st)
      ST_IDLE: begin
        if (REC_VALID) begin
          c_next.ev_raw = REC_EVENT;
          c_next.tm_raw = REC_TIME;
          c_next.stat = REC_STAT;
          c_next.st = ST_STAMP;
        end
      end
      ST_STAMP: begin
        c_next.ev_acc = ev_acc;
        c_next.tm_acc = tm_acc;
        c_next.tm_prev = c_reg.tm_raw;
        c_next.ev_have = start ? 1'b0 : c_reg.ev_have;
        c_next.have_ref = hv_ref;
        if (!arm_first) begin
          c_next.ev_prev = c_reg.ev_raw;
          c_next.ev_have = 1'b1;
          if (!hv_ref) begin
            c_next.ref_es = es; // first measurement sample
            c_next.ref_ts = ts;
            c_next.have_ref = 1'b1;
          end
        end
        c_next.prev_es = es;
        c_next.prev_ts = ts;
        c_next.have_prev = 1'b1;
        c_next.prev_arm = arm_first;
        c_next.dt = dt;
        c_next.func = fn;
        c_next.st = ST_IDLE;
        if (pair_ok) begin
          case (fn)
            FN_CTI, FN_TDEV: begin
              c_next.res_valid = 1'b1;
              c_next.res_invalid = 1'b0;
              c_next.res_func = fn;
              c_next.res_value = (fn == FN_CTI) ? dt : tdev;
              c_next.res_aux = (fn == FN_CTI) ? de - 1'b1 : '0;
            end
            FN_FREQ, FN_FDEV: begin
              dv.start = 1'b1;
              dv.dividend = de << FREQ_FRAC;
              dv.divisor = dt;
              c_next.st = ST_DIVIDE;
            end
            FN_PERIOD: begin
              dv.start = 1'b1;
              dv.dividend = dt << PER_FRAC;
              dv.divisor = de;
              c_next.st = ST_DIVIDE;
            end
            FN_PDEV: begin
              dv.start = 1'b1;
              dv.dividend = (tdev * DEG_FULL) << PHASE_FRAC;
              dv.divisor = DW'(a_reg.ref_per);
              c_next.st = ST_DIVIDE;
            end
            default: ; // unused function codes yield nothing
          endcase
        end
      end
      ST_DIVIDE: begin
        if (dv.done) begin
          c_next.res_valid = 1'b1;
          c_next.res_invalid = dv.zero;
          c_next.res_func = c_reg.func;
          c_next.res_value = dv.quotient;
          if (c_reg.func == FN_FDEV) begin
            c_next.res_value = dv.quotient - DW'(a_reg.ref_freq);
          end
          c_next.res_aux = '0;
          if (c_reg.func == FN_FREQ || c_reg.func == FN_PERIOD) begin
            c_next.res_aux = c_reg.dt; // gate time
          end
          // off-time samples would drag the carrier mean down
          if (c_reg.func == FN_FREQ && a_reg.ctrl[CTRL_AUTO_BIT] &&
              !c_reg.stat[STAT_INHIBIT_BIT] && !dv.zero) begin
            c_next.sum = c_reg.sum + dv.quotient;
            c_next.cnt = c_reg.cnt + 1'b1;
          end
          c_next.st = ST_IDLE;
        end
      end
      default: c_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) c_reg <= '0;
    else c_reg <= c_next;
  end

  stamp_divider #(.W(DW)) u_div (
    .clk(CLK),
    .rst_n(RST_N),
    .dv(dv.worker)
  );

  // result port, all from flip-flops
  assign REC_READY = (c_reg.st == ST_IDLE);
  assign RES_VALID = c_reg.res_valid;
  assign RES_VALUE = c_reg.res_value;
  assign RES_AUX = c_reg.res_aux;
  assign RES_INVALID = c_reg.res_invalid;
  assign RES_FUNC = c_reg.res_func;
endmodule
`default_nettype wire

// ===== bench/stamp_calc_monitor.sv
// checker for the stamp calculator's bus, record and result ports
// assumes it is bound into every stamp_result_calculator instance
`timescale 1ns/100ps
`default_nettype none
module stamp_calc_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [calc_pkg::DATA_W-1:0] S_AXI_RDATA,
  input wire logic REC_VALID,
  input wire logic REC_READY,
  input wire logic RES_VALID,
  input wire logic [calc_pkg::DW-1:0] RES_VALUE,
  input wire logic RES_INVALID,
  input wire logic [2:0] RES_FUNC
);
  import calc_pkg::*;
  // ==========================================================================
  // assertions, all on the one clock
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // address and data taken at one edge
  sequence both_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // response rises at the same edge as the register update
  sequence resp_late;
    !S_AXI_BVALID ##1 S_AXI_BVALID;
  endsequence
  write_answer_a: assert property (both_taken |=> resp_late)
    else $error("late write response");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID) else $error("late read data");
  arready_link_a: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("arready not tied");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  res_pulse_a: assert property (RES_VALID |=> !RES_VALID)
    else $error("long result valid");
  rec_busy_a: assert property (REC_VALID && REC_READY |=> !REC_READY)
    else $error("ready while busy");
  res_hold_a: assert property (1 ##1 !RES_VALID |->
    $stable(RES_VALUE) && $stable(RES_FUNC)) else $error("result changed");
  invalid_zero_a: assert property (
    RES_VALID && RES_INVALID |-> RES_VALUE == '0) else $error("bad invalid");
  cti_latency_a: assert property (
    RES_VALID && RES_FUNC == FN_CTI |->
    $past(REC_VALID, 2) && $past(REC_READY, 2)) else $error("cti latency");
endmodule

bind stamp_result_calculator stamp_calc_monitor stamp_calc_monitor_i (.*);
`default_nettype wire

// ===== bench/capture_model.sv
// capture side model: offers raw records one at a time
// assumes the calculator takes a record at an edge where ready is high
`timescale 1ns/100ps
`default_nettype none
module capture_model (
  input wire logic clk,
  input wire logic rec_ready,
  output logic rec_valid,
  output logic [31:0] rec_event,
  output logic [31:0] rec_time,
  output logic [calc_pkg::STAT_W-1:0] rec_stat
);
  int stuck = 0;
  // idle lines at time zero
  initial {rec_valid, rec_event, rec_time, rec_stat} = '0;
  // ==========================================================================
  // one record, held until taken or for 200 clocks; gap idles first to act slowly
  task automatic send(input int ev, tm, ip, start, arm, gap);
    bit taken = 0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    rec_valid <= 1'b1;
    rec_event <= (arm != 0) ? ~rec_event : 32'(ev);
    rec_time <= 32'(tm);
    rec_stat <= {1'b0, 1'(start), 6'(ip)};
    for (int i = 0; i < 200 && !taken; i++) begin
      @(posedge clk);
      taken = rec_ready;
    end
    if (!taken) stuck++;
    // released event and time lines toggle so stale data is never mistaken for a record
    rec_valid <= 1'b0;
    rec_event <= ~32'(ev);
    rec_time <= ~32'(tm);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the stamp result calculator
// assumes the capture model and the bound checker are compiled beside it
`timescale 1ns/100ps
`default_nettype none
module tb;
  import calc_pkg::*;
  typedef struct {logic [2:0] f; logic [63:0] v; logic [63:0] a; logic i;} res_t;
  logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, rec_valid, rec_ready;
  logic res_valid, res_invalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rec_event, rec_time;
  logic [7:0] rec_stat;
  logic [63:0] res_value, res_aux;
  logic [2:0] res_func;
  res_t rq[$];
  int fail_count = 0, n_checks = 0;

  always #5 clk = ~clk;

  stamp_result_calculator stamp_result_calculator_i (.CLK(clk), .RST_N(rst_n),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .REC_VALID(rec_valid),
    .REC_READY(rec_ready), .REC_EVENT(rec_event), .REC_TIME(rec_time),
    .REC_STAT(rec_stat), .RES_VALID(res_valid), .RES_VALUE(res_value),
    .RES_AUX(res_aux), .RES_INVALID(res_invalid), .RES_FUNC(res_func));
  capture_model cm (.clk(clk), .rec_ready(rec_ready),
    .rec_valid(rec_valid), .rec_event(rec_event), .rec_time(rec_time),
    .rec_stat(rec_stat));

  // results queued as they pulse
  always @(posedge clk) begin
    if (res_valid === 1'b1)
      rq.push_back('{res_func, res_value, res_aux, res_invalid});
  end
  // ==========================================================================
  // reporting and comparison
  task automatic complete_run();
    if (cm.stuck != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk_res(input logic [2:0] f, input logic [63:0] v,
      input logic [63:0] a, input logic i);
    res_t r;
    for (int k = 0; k < 300 && rq.size() == 0; k++) @(posedge clk);
    if (rq.size() == 0) begin
      fail_count++;
      complete_run();
    end
    r = rq.pop_front();
    n_checks++;
    if (r.f !== f || r.v !== v || r.a !== a || r.i !== i) begin
      fail_count++;
      $display("unexpected result at %0t: %h %h %h %h vs %h %h %h %h", $time,
        r.f, r.v, r.a, r.i, f, v, a, i);
    end
  endtask
  // ==========================================================================
  // register bus master; a hang ends the run
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d,
      output logic [1:0] r);
    bit done = 0;
    r = 2'h3;
    @(posedge clk);
    awvalid <= 1'b1; awaddr <= ad; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!done) begin fail_count++; complete_run(); end
  endtask
  // ready comes late on purpose so held read data is exercised
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d,
      output logic [1:0] r);
    bit done = 0;
    @(posedge clk);
    arvalid <= 1'b1; araddr <= ad;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready) begin
        done = 1; d = rdata; r = rresp; rready <= 1'b0;
      end else if (rvalid === 1'b1) rready <= 1'b1;
    end
    if (!done) begin fail_count++; complete_run(); end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(ad, d, r);
    chk_reg(32'(r), 32'(RESP_OKAY));
  endtask
  // ==========================================================================
  // scenarios
  task automatic test_regs();
    logic [31:0] d; logic [1:0] r;
    axi_rd(CTRL_OFS, d, r); chk_reg(d, REG_RST);
    wr(REF_PER_OFS, 32'h0000_00C8);
    axi_rd(REF_PER_OFS, d, r); chk_reg(d, 32'h0000_00C8);
    wr(STATUS_OFS, 32'hFFFF_FFFF); // read-only place ignores writes
    axi_rd(STATUS_OFS, d, r); chk_reg(d, 32'h0000_0000);
    axi_wr(8'h40, 32'h1, r); chk_reg(32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h40, d, r); chk_reg(32'(r), 32'(RESP_SLVERR));
    $display("test_regs done");
  endtask
  task automatic test_roll();
    wr(EV_CORR_OFS, 32'd100); wr(TM_CORR_OFS, 32'd1000); wr(CTRL_OFS, 32'h0);
    cm.send(10, 100, 5, 1, 0, 0);
    cm.send(13, 150, 2, 0, 0, 0);
    cm.send(5, 40, 0, 0, 0, 0);
    chk_res(FN_CTI, 64'd1003, 64'd2, 1'b0);
    chk_res(FN_CTI, 64'd17802, 64'd91, 1'b0);
    cm.send(50, 10, 0, 1, 0, 4);
    cm.send(52, 20, 0, 0, 0, 0);
    chk_res(FN_CTI, 64'd200, 64'd1, 1'b0);
    wr(CTRL_OFS, 32'h8);
    cm.send(10, 0, 0, 1, 0, 0);
    cm.send(13, 5, 0, 0, 0, 0);
    cm.send(5, 10, 0, 0, 0, 0);
    chk_res(FN_CTI, 64'd100, 64'd11, 1'b0);
    chk_res(FN_CTI, 64'd100, 64'd367, 1'b0);
    $display("test_roll done");
  endtask
  task automatic test_arm();
    wr(PATH_OFS_OFS, 32'd7); wr(CTRL_OFS, 32'h10);
    cm.send(0, 100, 0, 1, 1, 0);
    cm.send(5, 110, 0, 0, 0, 0);
    cm.send(8, 130, 0, 0, 0, 0);
    chk_res(FN_CTI, 64'd400, 64'd2, 1'b0);
    repeat (5) @(posedge clk);
    chk_reg(32'(rq.size()), 32'h0);
    $display("test_arm done");
  endtask
  task automatic test_quot();
    logic [31:0] d; logic [1:0] r;
    wr(CTRL_OFS, 32'h2);
    cm.send(0, 0, 0, 1, 0, 0);
    cm.send(4, 50, 0, 0, 0, 0);
    chk_res(FN_PERIOD, 64'hFA00, 64'd1000, 1'b0);
    wr(CTRL_OFS, 32'h21);
    cm.send(0, 0, 0, 1, 0, 0);
    cm.send(2, 10, 0, 0, 0, 0);
    cm.send(0, 0, 0, 1, 0, 0);
    cm.send(3, 0, 0, 0, 0, 0);
    chk_res(FN_FREQ, 64'h28F_5C28, 64'd200, 1'b0);
    chk_res(FN_FREQ, 64'h0, 64'h0, 1'b1);
    axi_rd(COUNT_OFS, d, r); chk_reg(d, 32'h1);
    axi_rd(SUM_LO_OFS, d, r); chk_reg(d, 32'h028F_5C28);
    $display("test_quot done");
  endtask
  task automatic test_dev();
    logic [63:0] ex[6] = '{-64'h14, -64'h28, -64'h2400, -64'h4800,
      -64'h8, -64'h8};
    wr(REF_PER_OFS, 32'd200); wr(REF_FREQ_OFS, 32'h0129_E41A);
    for (int k = 0; k < 3; k++) begin
      wr(CTRL_OFS, 32'(k + 3));
      cm.send(0, 0, 0, 1, 0, 0);
      cm.send(1, 11, 0, 0, 0, 0);
      cm.send(2, 22, 0, 0, 0, 2);
      chk_res(3'(k + 3), ex[2 * k], 64'h0, 1'b0);
      chk_res(3'(k + 3), ex[2 * k + 1], 64'h0, 1'b0);
    end
    $display("test_dev done");
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_roll();
    test_arm();
    test_quot();
    test_dev();
    complete_run();
  end
endmodule
`default_nettype wire
